// >>> verilog/two_level_interrupt_unit.sv
// Fourteen-source two-level interrupt unit with APB registers and vector output.
// Behaviour
// R1: Fourteen sources: two lines, timers, serial, eight.
// R2: Taken interrupt jumps to its own vector.
// R3: Each source has an enable bit.
// R4: Global enable gates every source.
// R5: First enable register bit layout fixed.
// R6: Second enable register enables lines two-nine.
// R7: Two priority levels, high preempts low.
// R8: Lines two-nine enter on first port.
// R9: Lines zero, one from third port.
// R10: Lines two-nine are level sensitive.
// R11: Enabled port line wakes from power-down.
// R12: Polarity register selects active level.
// R13: Pending flag sticks until software clears.
// R14: Software clears flag before service returns.
// R15: Pending register bit0 line2 to bit7 line9.
// R16: Fixed order resolves same-level simultaneous requests.
// R17: Pins pass two flip-flops before use.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module two_level_interrupt_unit
  import irq_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_line0,
  input wire logic ext_line1,
  input wire logic [7:0] port1_pins,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic serial_request,
  output logic cpu_irq_req,
  output logic [15:0] cpu_vector,
  output logic power_down_bit,
  output logic wake_up,
  output logic irq
);
  // State of the unit, apart from the pin synchroniser chain, in one packed struct.
  typedef struct packed {
    logic [7:0] enable0;
    logic [7:0] enable1;
    logic [7:0] prio0;
    logic [7:0] prio1;
    logic [7:0] polarity;
    logic [7:0] pending;
    logic [1:0] status;
    logic [1:0] mask;
    logic power_down;
    logic wake;
    lvl_t level;
    logic low_saved;
    logic req;
    logic [15:0] vector;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [9:0] pins_synced;
  logic [NUM_SRC-1:0] request;
  logic [NUM_SRC-1:0] enabled;
  logic [NUM_SRC-1:0] en_mask;
  logic [NUM_SRC-1:0] high_sel;
  logic [7:0] line_active;
  logic bus_access;
  logic bus_write;
  logic bus_read;
  logic hit;
  logic [3:0] win_idx;
  logic win_valid;
  logic win_high;

  // Per-source vector by source number taken from a pair of enable or priority registers.
  function automatic logic [NUM_SRC-1:0] spread(input logic [7:0] r0, input logic [7:0] r1);
    spread = {r1, r0[EN0_TIMER2], r0[EN0_SERIAL], r0[EN0_TIMER1], r0[EN0_LINE1],
              r0[EN0_TIMER0], r0[EN0_LINE0]};
  endfunction : spread

  // Address decode used by the error response and write path.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_ENABLE0) || (a == ADDR_ENABLE1) || (a == ADDR_PRIO0) || (a == ADDR_PRIO1) ||
                (a == ADDR_POLARITY) || (a == ADDR_PENDING) || (a == ADDR_STATUS) ||
                (a == ADDR_MASK) || (a == ADDR_CONTROL) || (a == ADDR_SERVICE);
  endfunction : is_mapped

  // R17 two-stage sync
  // Port pins enter inverted, so the cleared chain matches their pulled-up idle level after reset.
  pin_sync #(
    .WIDTH(10),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async({~port1_pins, ext_line1, ext_line0}),
    .pin_sync_out(pins_synced)
  );

  // R10 R12 level polarity
  // The chain holds inverted port pins, so a line is active where its stored bit differs from its polarity bit.
  assign line_active = pins_synced[9:2] ^ st_ff.polarity;

  // Raw requests by source number; R1 fourteen sources, R9 R8 pin mapping.
  assign request = {st_ff.pending, timer2_overflow, serial_request, timer1_overflow,
                    pins_synced[1], timer0_overflow, pins_synced[0]};

  // R3 R4 R6 enable gating
  // Per-source enables in source order, before the global gate.
  assign en_mask = spread(st_ff.enable0, st_ff.enable1);
  // A source may interrupt only with its own bit and the global bit both set.
  assign enabled = request & en_mask & {NUM_SRC{st_ff.enable0[EN0_GLOBAL]}};
  // R7 priority select per source
  assign high_sel = spread(st_ff.prio0, st_ff.prio1);

  // R16 fixed poll order, high level first.
  always_comb begin
    win_idx = 4'h0;
    win_valid = 1'b0;
    win_high = 1'b0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (enabled[POLL_ORDER[k]] && !high_sel[POLL_ORDER[k]]) begin
        win_idx = POLL_ORDER[k];
        win_valid = 1'b1;
      end
    end
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (enabled[POLL_ORDER[k]] && high_sel[POLL_ORDER[k]]) begin
        win_idx = POLL_ORDER[k];
        win_valid = 1'b1;
        win_high = 1'b1;
      end
    end
  end

  // APB handshake: zero wait states.
  assign bus_access = psel && penable;
  assign bus_write = bus_access && pwrite;
  assign bus_read = bus_access && !pwrite;
  assign hit = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = bus_access && !hit;

  // Next-state logic for registers, flags, and the service level tracker.
  always_comb begin
    logic preempt_ok;
    logic [7:0] wb;
    preempt_ok = 1'b0;
    wb = pwdata[7:0];
    nxt_st = st_ff;
    nxt_st.req = 1'b0;
    // Register writes.
    if (bus_write && hit) begin
      case (paddr)
        ADDR_ENABLE0: nxt_st.enable0 = wb & 8'hbf;
        ADDR_ENABLE1: nxt_st.enable1 = wb;
        ADDR_PRIO0: nxt_st.prio0 = wb & 8'h3f;
        ADDR_PRIO1: nxt_st.prio1 = wb;
        ADDR_POLARITY: nxt_st.polarity = wb;
        // R13 software clear of flags by writing zero
        ADDR_PENDING: nxt_st.pending = st_ff.pending & wb;
        ADDR_MASK: nxt_st.mask = wb[1:0];
        ADDR_CONTROL: begin
          nxt_st.power_down = wb[CTL_POWER_DOWN];
          // R7 return ends the current level
          if (wb[CTL_RETURN]) begin
            if (st_ff.level == LVL_HIGH && st_ff.low_saved) begin
              nxt_st.level = LVL_LOW;
            end else begin
              nxt_st.level = LVL_IDLE;
            end
            nxt_st.low_saved = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Status read clears only the bits that the access returns.
    // An event that lands in the setup cycle is not in the returned data, so it survives.
    if (bus_read && paddr == ADDR_STATUS) begin
      nxt_st.status = st_ff.status & ~st_ff.rdata[1:0];
    end
    // R13 hardware set wins over clear
    nxt_st.pending = nxt_st.pending | line_active;
    // R11 wake on enabled port line
    // The wake-up pulse lasts one cycle, and power-down drops at the same edge.
    if (st_ff.power_down && |(line_active & st_ff.enable1)) begin
      nxt_st.power_down = 1'b0;
      nxt_st.wake = 1'b1;
      nxt_st.status[STS_WAKE] = 1'b1;
    end else begin
      nxt_st.wake = 1'b0;
    end
    // R7 preemption allowed only by a strictly higher level.
    case (st_ff.level)
      LVL_IDLE: preempt_ok = win_valid;
      LVL_LOW: preempt_ok = win_valid && win_high;
      LVL_HIGH: preempt_ok = 1'b0;
      default: preempt_ok = 1'b0;
    endcase
    // Power-down holds acceptance off until a wake-up or a control write with bit 0 clear drops it.
    // R2 vectoring on accept
    if (preempt_ok && !st_ff.power_down) begin
      nxt_st.req = 1'b1;
      nxt_st.vector = VECTOR_OF[win_idx];
      nxt_st.low_saved = (st_ff.level == LVL_LOW);
      nxt_st.level = win_high ? LVL_HIGH : LVL_LOW;
      nxt_st.status[STS_TAKEN] = 1'b1;
    end
    // Read data mux, registered for the access cycle.
    nxt_st.rdata = 32'h0000_0000;
    case (paddr)
      // R5 first enable layout
      ADDR_ENABLE0: nxt_st.rdata[7:0] = st_ff.enable0;
      ADDR_ENABLE1: nxt_st.rdata[7:0] = st_ff.enable1;
      ADDR_PRIO0: nxt_st.rdata[7:0] = st_ff.prio0;
      ADDR_PRIO1: nxt_st.rdata[7:0] = st_ff.prio1;
      ADDR_POLARITY: nxt_st.rdata[7:0] = st_ff.polarity;
      // R15 pending bit order
      ADDR_PENDING: nxt_st.rdata[7:0] = st_ff.pending;
      ADDR_STATUS: nxt_st.rdata[1:0] = st_ff.status;
      ADDR_MASK: nxt_st.rdata[1:0] = st_ff.mask;
      ADDR_CONTROL: nxt_st.rdata[0] = st_ff.power_down;
      ADDR_SERVICE: nxt_st.rdata = {12'h000, 2'(st_ff.level), st_ff.low_saved, 1'b0, st_ff.vector};
      default: nxt_st.rdata = 32'h0000_0000;
    endcase
  end

  // Register the whole state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{enable0: RESET_BYTE, enable1: RESET_BYTE, prio0: RESET_BYTE, prio1: RESET_BYTE,
                 polarity: RESET_BYTE, pending: RESET_BYTE, status: 2'b00, mask: 2'b00,
                 power_down: 1'b0, wake: 1'b0, level: LVL_IDLE, low_saved: 1'b0, req: 1'b0,
                 vector: 16'h0000, rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Read data is captured from the mux at the edge that ends the setup cycle.
  // It then stands unchanged through the access phase; the cost is that a value
  // changed by hardware during the setup cycle shows only on the next read.
  assign prdata = st_ff.rdata;
  assign cpu_irq_req = st_ff.req;
  assign cpu_vector = st_ff.vector;
  assign power_down_bit = st_ff.power_down;
  assign wake_up = st_ff.wake;
  assign irq = |(st_ff.status & st_ff.mask);

  // R4 global enable off means no request
  chk_global_gate: assert property (@(posedge pclk) disable iff (!presetn) // R4
    !st_ff.enable0[EN0_GLOBAL] |=> !cpu_irq_req)
    else $error("Interrupt taken with global enable clear");

  // R13 flag holds without a clearing write
  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R13
    !(bus_write && paddr == ADDR_PENDING) |=> (st_ff.pending & $past(st_ff.pending)) == $past(st_ff.pending))
    else $error("Pending flag dropped without software clear");

  // R10 active level sets the flag
  chk_level_sets: assert property (@(posedge pclk) disable iff (!presetn) // R10
    |line_active |=> (st_ff.pending & $past(line_active)) == $past(line_active))
    else $error("Active line did not set its flag");

  // R2 vector matches winning source
  chk_vector_map: assert property (@(posedge pclk) disable iff (!presetn) // R2
    nxt_st.req |=> cpu_vector == VECTOR_OF[$past(win_idx)])
    else $error("Vector does not match winning source");

  // R16 line zero wins its level
  // Line zero wins whenever it stands at the level of the winner.
  chk_line0_first: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (enabled[0] && (high_sel[0] == win_high)) |-> win_idx == 4'h0)
    else $error("Line zero lost same-level arbitration");

  // R7 no take while high level in service
  chk_high_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (st_ff.level == LVL_HIGH && !bus_write) |=> !cpu_irq_req)
    else $error("Interrupt taken during high-level service");

  // R11 wake on enabled line
  chk_wake_exit: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (power_down_bit && |(line_active & st_ff.enable1)) |=> (wake_up && !power_down_bit))
    else $error("Enabled line failed to wake");

  // R3 disabled source never vectors
  chk_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // R3
    nxt_st.req |-> (request[win_idx] && en_mask[win_idx] && st_ff.enable0[EN0_GLOBAL]))
    else $error("Disabled source was taken");

  // R12 polarity applied to line two
  chk_polarity: assert property (@(posedge pclk) disable iff (!presetn) // R12
    line_active[0] == ($past(port1_pins[0], 2) == st_ff.polarity[0]))
    else $error("Polarity not applied");
endmodule : two_level_interrupt_unit

// >>> verilog/irq_unit_pkg.sv
// Package with register map, field layout, vector table and timing constants of the interrupt unit.
package irq_unit_pkg;
  // Register byte addresses on APB (printed offsets used directly, own choices for the rest).
  localparam logic [11:0] ADDR_ENABLE0 = 12'h0a8;
  localparam logic [11:0] ADDR_ENABLE1 = 12'h0ac;
  localparam logic [11:0] ADDR_PRIO0 = 12'h0b8;
  localparam logic [11:0] ADDR_PRIO1 = 12'h0bc;
  localparam logic [11:0] ADDR_POLARITY = 12'h0e8;
  localparam logic [11:0] ADDR_PENDING = 12'h0c0;
  localparam logic [11:0] ADDR_STATUS = 12'h0f0;
  localparam logic [11:0] ADDR_MASK = 12'h0f4;
  localparam logic [11:0] ADDR_CONTROL = 12'h0f8;
  localparam logic [11:0] ADDR_SERVICE = 12'h0fc;
  // Bit positions inside the first enable register.
  localparam int EN0_LINE0 = 0;
  localparam int EN0_TIMER0 = 1;
  localparam int EN0_LINE1 = 2;
  localparam int EN0_TIMER1 = 3;
  localparam int EN0_SERIAL = 4;
  localparam int EN0_TIMER2 = 5;
  localparam int EN0_GLOBAL = 7;
  // Control register bits: power-down request and return-from-service strobe.
  localparam int CTL_POWER_DOWN = 0;
  localparam int CTL_RETURN = 1;
  // Status register bits: taken, wake-up.
  localparam int STS_TAKEN = 0;
  localparam int STS_WAKE = 1;
  localparam int NUM_SRC = 14;
  localparam int NUM_PIN = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Source index in order of fixed same-level priority, highest first.
  typedef logic [3:0] src_idx_t;
  // Source numbering: 0 line0, 1 timer0, 2 line1, 3 timer1, 4 serial, 5 timer2, 6..13 lines 2..9.
  localparam src_idx_t POLL_ORDER [NUM_SRC] = '{4'h0, 4'h4, 4'h9, 4'h1, 4'ha, 4'h2, 4'h6,
                                                 4'hb, 4'h3, 4'h5, 4'h7, 4'hc, 4'h8, 4'hd};
  // Vector address of each source by source number.
  localparam logic [15:0] VECTOR_OF [NUM_SRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
                                                   16'h0023, 16'h002b, 16'h003b, 16'h0043,
                                                   16'h004b, 16'h0053, 16'h005b, 16'h0063,
                                                   16'h006b, 16'h0073};
  // Synchroniser depth and clock figures.
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 40;
  // Service level encoding.
  typedef enum logic [1:0] {LVL_IDLE, LVL_LOW, LVL_HIGH} lvl_t;
endpackage : irq_unit_pkg

// >>> verilog/pin_sync.sv
// Multi-stage synchroniser for asynchronous request pins.
`timescale 1ns/1ps
module pin_sync
  import irq_unit_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync_out
);
  // Chain of flops, stage 0 read only by stage 1.
  logic [WIDTH-1:0] chain_ff [STAGES];

  // Elaboration check: fewer than two stages is no synchroniser.
  if (STAGES < 2) begin : g_bad
    $error("pin_sync needs at least two stages");
  end

  // Shift the pins through the chain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_ff[i] <= '0;
      end
    end else begin
      chain_ff[0] <= pin_async;
      for (int i = 1; i < STAGES; i++) begin
        chain_ff[i] <= chain_ff[i-1];
      end
    end
  end

  assign pin_sync_out = chain_ff[STAGES-1];
endmodule : pin_sync

// >>> tb/cpu_core_model.sv
// Behavioural core that counts accepted interrupts and keeps the last vector.
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_irq_req,
  input wire logic [15:0] cpu_vector,
  output logic [7:0] taken_ff,
  output logic [15:0] vec_ff
);
  // jump to vector
  // Each accept pulse counts once and latches the vector the core would fetch from.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_ff <= 8'h00;
      vec_ff <= 16'h0000;
    end else if (cpu_irq_req) begin
      taken_ff <= taken_ff + 8'h01;
      vec_ff <= cpu_vector;
    end
  end
endmodule : cpu_core_model

// >>> tb/tb.sv
// Self-checking bench for the two-level interrupt unit.
`timescale 1ns/1ps
module tb;
  import irq_unit_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q, rd;
  logic pready, pslverr, err_q, err_r, rdy_q, cpu_irq_req, power_down_bit, wake_up, irq, irq_q, pd_q;
  logic [15:0] cpu_vector, vseen, last_vec;
  logic [13:0] src = 14'h0;
  logic [7:0] pol = 8'h00, taken_ff;
  int miscompares = 0, num_checks = 0, nacc = 0, seen = 0, wks = 0, a, b;
  // Fixed same-level rank of each source number, zero is served first.
  localparam int RANK [14] = '{0, 3, 5, 8, 1, 9, 6, 10, 12, 2, 4, 7, 11, 13};
  localparam logic [11:0] REGS [7] = '{ADDR_ENABLE0, ADDR_ENABLE1, ADDR_PRIO0, ADDR_PRIO1,
                                       ADDR_POLARITY, ADDR_PENDING, ADDR_MASK};

  // Clock of 40 ns period.
  always #20 pclk = ~pclk;

  // Outputs are sampled before each rising edge, so they show what that edge sees.
  always @(negedge pclk) begin
    rd_q = prdata;
    err_q = pslverr;
    rdy_q = pready;
    irq_q = irq;
    pd_q = power_down_bit;
    if (cpu_irq_req === 1'b1) begin
      seen++;
      vseen = cpu_vector;
    end
    if (wake_up === 1'b1) begin
      wks++;
    end
  end

  two_level_interrupt_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_line0(src[0]), .ext_line1(src[2]), .port1_pins(~(src[13:6] ^ pol)), .timer0_overflow(src[1]),
    .timer1_overflow(src[3]), .timer2_overflow(src[5]), .serial_request(src[4]), .cpu_irq_req(cpu_irq_req),
    .cpu_vector(cpu_vector), .power_down_bit(power_down_bit), .wake_up(wake_up), .irq(irq));

  cpu_core_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_irq_req(cpu_irq_req),
    .cpu_vector(cpu_vector), .taken_ff(taken_ff), .vec_ff(last_vec));

  // Vector address expected for a source number.
  function automatic logic [15:0] exp_vec(input int i);
    exp_vec = (i < 6) ? 16'(16'h0003 + 8 * i) : 16'(16'h003b + 8 * (i - 6));
  endfunction : exp_vec

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge; holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready that never finishes.
    do begin
      @(posedge pclk);
    end while (rdy_q !== 1'b1);
    rd = rd_q;
    err_r = err_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask : wr

  task automatic rdc(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(rd, e);
    chk(err_r, 1'b0);
  endtask : rdc

  // Waits for one accept under a bound and checks its vector.
  task automatic acc(input logic [15:0] e);
    int n;
    n = 0;
    while (seen == nacc && n < 30) begin
      @(posedge pclk);
      n++;
    end
    chk(seen, nacc + 1);
    nacc = seen;
    chk(vseen, e);
  endtask : acc

  // No accept may appear for twelve cycles.
  task automatic quiet();
    repeat (12) @(posedge pclk);
    chk(seen, nacc);
  endtask : quiet

  // Ends a service: drops requests, clears every pending flag and returns.
  task automatic done();
    src <= 14'h0;
    repeat (5) @(posedge pclk);
    wr(ADDR_PENDING, 32'h0);
    wr(ADDR_CONTROL, 32'h2);
  endtask : done

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    summarize();
  end

  // Main sequence of tests.
  initial begin
    a = $urandom(20);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (REGS[k]) rdc(REGS[k], 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(err_r, 1'b1);
    $display("test reset done");
    b = $urandom;
    wr(ADDR_POLARITY, {24'h0, 8'(b)});
    rdc(ADDR_POLARITY, {24'h0, 8'(b)});
    pol <= 8'(b);
    done();
    wr(ADDR_MASK, 32'h1);
    for (int i = 0; i < 14; i++) begin
      wr(ADDR_ENABLE0, {24'h0, 2'b10, 6'(14'h1 << i)});
      wr(ADDR_ENABLE1, {24'h0, 8'((14'h1 << i) >> 6)});
      src <= 14'h1 << i;
      acc(exp_vec(i));
      chk(irq_q, 1'b1);
      if (i > 5) begin
        src <= 14'h0;
        repeat (5) @(posedge pclk);
        rdc(ADDR_PENDING, 32'h1 << (i - 6));
        wr(ADDR_CONTROL, 32'h2);
        acc(exp_vec(i));
      end
      rdc(ADDR_STATUS, 32'h1);
      chk(irq_q, 1'b0);
      done();
    end
    $display("test vectors done");
    wr(ADDR_ENABLE0, 32'h3f);
    wr(ADDR_ENABLE1, 32'hff);
    src <= 14'h3fff;
    quiet();
    done();
    wr(ADDR_ENABLE0, 32'h80);
    wr(ADDR_ENABLE1, 32'h0);
    src <= 14'h3fff;
    quiet();
    done();
    $display("test gating done");
    wr(ADDR_ENABLE1, 32'hff);
    repeat (10) begin
      a = $urandom_range(13);
      b = $urandom_range(13);
      wr(ADDR_ENABLE0, 32'h3f);
      src <= (14'h1 << a) | (14'h1 << b);
      repeat (6) @(posedge pclk);
      wr(ADDR_ENABLE0, 32'hbf);
      acc(exp_vec(RANK[a] < RANK[b] ? a : b));
      done();
    end
    $display("test same level order done");
    wr(ADDR_PRIO1, 32'h80);
    src <= 14'h0001;
    acc(16'h0003);
    src <= 14'h0003;
    quiet();
    src <= 14'h2003;
    acc(16'h0073);
    rdc(ADDR_SERVICE, {12'h000, 2'(LVL_HIGH), 1'b1, 1'b0, 16'h0073});
    done();
    wr(ADDR_CONTROL, 32'h2);
    quiet();
    wr(ADDR_PRIO1, 32'h0);
    $display("test preemption done");
    wr(ADDR_ENABLE0, 32'h80);
    wr(ADDR_ENABLE1, 32'h1);
    wr(ADDR_CONTROL, 32'h1);
    chk(pd_q, 1'b1);
    src <= 14'h0040;
    for (int n = 0; n < 30 && wks == 0; n++) @(posedge pclk);
    chk(wks, 1);
    chk(pd_q, 1'b0);
    acc(exp_vec(6));
    rdc(ADDR_STATUS, 32'h3);
    done();
    chk(taken_ff, seen[7:0]);
    chk(last_vec, exp_vec(6));
    $display("test wake done");
    summarize();
  end
endmodule : tb
